/* File: scs_top.sv */
`timescale 1ns/1ps
`include "scs_cfg.svh"

// Overview of operation
// - external pin clock may replace baud divider; uart bit rate is pin clock over 16
// - shift mode with external clock moves one bit per pin clock period
// - timer trigger is never a clock source in shift mode
// - timer clocked channel: rate is prescaler clock over compare times 2 times 16
// - shift mode, direction 0: pin is output, base clock is divider over two
// - shift mode, direction 1: base clock from pin, edge chosen by select bit
// - uart mode: two-bit field picks divider, half clock, timer or pin
// - uart receiver has 4-bit up counter advanced by each base clock
// - sixteen base clocks per bit, samples on seventh, eighth and ninth
// - bit value is the majority of the three samples
// - shift mode, driven clock: data sampled on its rising edge
// - shift mode, external clock: data sampled on selected edge
// - uart receiver waits for valid start bit before sampling character
// - majority vote applies to start, data and stop bits alike
// - fraction disabled: divider divides by integer divisor 1 to 16
// - fraction enabled (uart mode only), N and K not 0: divides by N plus (16 minus K) over 16
// - divider rate then over 16 in uart mode, over 2 in shift mode

module scs_top (
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        shift_clock_pin_i,
    output logic             shift_clock_pin_o,
    output logic             shift_clock_pin_oe_o,
    input  wire logic        receive_data_pin_i,
    output logic             rx_bit_valid_o,
    output logic             rx_bit_o,
    output logic             rx_frame_done_o
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_q, rst_n;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [5:0]  mode_q, mode_d;
    logic [10:0] baud_q, baud_d;
    logic [7:0]  timer_q, timer_d;
    logic [31:0] rdata_d;
    logic        ack_q, ack_d;
    logic [2:0]  rx_stat;

    // one wait state: every access ends at the second edge, where writes land
    always_comb begin
        mode_d  = mode_q;
        baud_d  = baud_q;
        timer_d = timer_q;
        ack_d   = (avs_read_i || avs_write_i) && !ack_q;
        rdata_d = avs_readdata_o;
        if (ack_q && avs_write_i) begin
            case (avs_address_i)
                `SCS_OFS_MODE:  mode_d  = avs_writedata_i[5:0];
                `SCS_OFS_BAUD:  baud_d  = avs_writedata_i[10:0];
                `SCS_OFS_TIMER: timer_d = avs_writedata_i[7:0];
                default:        mode_d  = mode_q;
            endcase
        end
        if (ack_d && avs_read_i) begin
            case (avs_address_i)
                `SCS_OFS_MODE:   rdata_d = {26'h0000000, mode_q};
                `SCS_OFS_BAUD:   rdata_d = {21'h000000, baud_q};
                `SCS_OFS_TIMER:  rdata_d = {24'h000000, timer_q};
                `SCS_OFS_STATUS: rdata_d = {29'h00000000, rx_stat};
                default:         rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            mode_q            <= `SCS_MODE_RST;
            baud_q            <= `SCS_BAUD_RST;
            timer_q           <= `SCS_TIMER_RST;
            ack_q             <= 1'b0;
            avs_readdata_o    <= 32'h00000000;
        end else begin
            mode_q            <= mode_d;
            baud_q            <= baud_d;
            timer_q           <= timer_d;
            ack_q             <= ack_d;
            avs_readdata_o    <= rdata_d;
        end
    end
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;

    logic                 uart_mode, clk_dir_in, edge_fall, rx_en;
    scs_pkg::scs_src_t    src_sel;
    assign uart_mode  = mode_q[`SCS_MODE_UART_BIT];
    assign src_sel    = scs_pkg::scs_src_t'(mode_q[`SCS_MODE_SRC_LO +: 2]);
    assign clk_dir_in = mode_q[`SCS_MODE_DIR_BIT];
    assign edge_fall  = mode_q[`SCS_MODE_EDGE_BIT];
    assign rx_en      = mode_q[`SCS_MODE_RXEN_BIT];

    // ------------------------------------------------------------
    // prescaler and clock sources
    // ------------------------------------------------------------
    logic [7:0] pre_q, pre_d;
    logic       pre_tap, half_tick, baud_tick, timer_tick;

    function automatic logic tap_hit(input logic [7:0] cnt, input logic [1:0] sel);
        case (sel)
            2'b00:   tap_hit = 1'b1;
            2'b01:   tap_hit = (cnt[1:0] == 2'b11);
            2'b10:   tap_hit = (cnt[3:0] == 4'hf);
            default: tap_hit = (cnt[5:0] == 6'h3f);
        endcase
    endfunction : tap_hit

    always_comb begin
        pre_d = pre_q + 8'h01;
    end
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 8'h00;
        end else begin
            pre_q <= pre_d;
        end
    end
    assign pre_tap   = tap_hit(pre_q, baud_q[`SCS_BAUD_PRE_LO +: 2]);
    assign half_tick = pre_q[0];

    scs_baud_div u_baud (
        .clk_i      (clk_sys_i),
        .rst_n_i    (rst_n),
        .in_en_i    (pre_tap),
        .divisor_i  (baud_q[`SCS_BAUD_N_LO +: 4]),
        .fraction_i (baud_q[`SCS_BAUD_K_LO +: 4]),
        .frac_en_i  (baud_q[`SCS_BAUD_FEN_BIT] && uart_mode),
        .tick_o     (baud_tick)
    );

    scs_timer8 u_timer (
        .clk_i     (clk_sys_i),
        .rst_n_i   (rst_n),
        .in_en_i   (pre_tap),
        .compare_i (timer_q),
        .trig_o    (timer_tick)
    );

    // ------------------------------------------------------------
    // pin edge detection (pin taken as synchronous)
    // ------------------------------------------------------------
    logic pin_q, rxd_q;
    logic pin_rise, pin_fall;
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            // idle level of the pin, so no false edge follows reset
            pin_q <= 1'b1;
            rxd_q <= 1'b1;
        end else begin
            pin_q <= shift_clock_pin_i;
            rxd_q <= receive_data_pin_i;
        end
    end
    assign pin_rise = shift_clock_pin_i && !pin_q;
    assign pin_fall = !shift_clock_pin_i && pin_q;

    // ------------------------------------------------------------
    // serial base clock selection
    // ------------------------------------------------------------
    logic base_tick, sclk_q, sclk_d, sample_shift;
    always_comb begin
        sclk_d       = sclk_q;
        base_tick    = 1'b0;
        sample_shift = 1'b0;
        if (uart_mode) begin
            case (src_sel)
                scs_pkg::SCS_SRC_BAUD:  base_tick = baud_tick;
                scs_pkg::SCS_SRC_HALF:  base_tick = half_tick;
                scs_pkg::SCS_SRC_TIMER: base_tick = timer_tick;
                scs_pkg::SCS_SRC_PIN:   base_tick = pin_rise;
                default:                base_tick = 1'b0;
            endcase
        end else if (!clk_dir_in) begin
            // driven clock: divider over two, sample on our rising edge
            if (baud_tick) begin
                sclk_d = ~sclk_q;
            end
            base_tick    = baud_tick && !sclk_q;
            sample_shift = base_tick;
        end else begin
            // one bit per pin period; timer never reaches here
            base_tick    = edge_fall ? pin_fall : pin_rise;
            sample_shift = base_tick;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 1'b1;
        end else begin
            sclk_q <= sclk_d;
        end
    end

    // ------------------------------------------------------------
    // uart receive counter and majority sampler
    // ------------------------------------------------------------
    scs_pkg::scs_rx_state_t st_q, st_d;
    logic [3:0] os_q, os_d;
    logic [3:0] bits_q, bits_d;
    logic [2:0] smp_q, smp_d;
    logic       bit_v_d, bit_d, done_d;

    function automatic logic vote3(input logic [2:0] s);
        vote3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
    endfunction : vote3

    always_comb begin
        st_d    = st_q;
        os_d    = os_q;
        bits_d  = bits_q;
        smp_d   = smp_q;
        bit_v_d = 1'b0;
        bit_d   = rx_bit_o;
        done_d  = 1'b0;
        if (!rx_en) begin
            st_d = scs_pkg::SCS_RX_IDLE;
        end else if (!uart_mode) begin
            st_d = scs_pkg::SCS_RX_IDLE;
            if (sample_shift) begin
                bit_v_d = 1'b1;
                bit_d   = receive_data_pin_i;
            end
        end else begin
            case (st_q)
                scs_pkg::SCS_RX_IDLE: begin
                    if (base_tick && !rxd_q) begin
                        st_d   = scs_pkg::SCS_RX_START;
                        os_d   = 4'h0;
                        bits_d = 4'h0;
                    end
                end
                scs_pkg::SCS_RX_START,
                scs_pkg::SCS_RX_DATA: begin
                    if (base_tick) begin
                        os_d = os_q + 4'h1;
                        if (os_q >= `SCS_SAMPLE_FIRST && os_q <= `SCS_SAMPLE_LAST) begin
                            smp_d = {smp_q[1:0], rxd_q};
                        end
                        if (os_q == `SCS_SAMPLE_LAST + 4'h1) begin
                            bit_v_d = 1'b1;
                            bit_d   = vote3(smp_q);
                            if (st_q == scs_pkg::SCS_RX_START && vote3(smp_q)) begin
                                st_d = scs_pkg::SCS_RX_IDLE;    // false start
                                bit_v_d = 1'b0;
                            end else if (bits_q == `SCS_FRAME_BITS - 4'h1) begin
                                st_d   = scs_pkg::SCS_RX_IDLE;
                                done_d = 1'b1;
                            end else begin
                                st_d   = scs_pkg::SCS_RX_DATA;
                                bits_d = bits_q + 4'h1;
                            end
                        end
                    end
                end
                default: st_d = scs_pkg::SCS_RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            st_q            <= scs_pkg::SCS_RX_IDLE;
            os_q            <= 4'h0;
            bits_q          <= 4'h0;
            smp_q           <= 3'h0;
            rx_bit_valid_o  <= 1'b0;
            rx_bit_o        <= 1'b1;
            rx_frame_done_o <= 1'b0;
            shift_clock_pin_o    <= 1'b1;
            shift_clock_pin_oe_o <= 1'b0;
        end else begin
            st_q            <= st_d;
            os_q            <= os_d;
            bits_q          <= bits_d;
            smp_q           <= smp_d;
            rx_bit_valid_o  <= bit_v_d;
            rx_bit_o        <= bit_d;
            rx_frame_done_o <= done_d;
            shift_clock_pin_o    <= sclk_d;
            shift_clock_pin_oe_o <= !uart_mode && !clk_dir_in;
        end
    end
    assign rx_stat = {uart_mode, st_q};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_vote_result: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (uart_mode && bit_v_d) |-> bit_d == (2'(smp_q[0]) + 2'(smp_q[1]) + 2'(smp_q[2]) >= 2'h2))
        else $error("vote result wrong");
    a_sample_slot: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (smp_d != smp_q) |-> (os_q >= 4'h6 && os_q <= 4'h8))
        else $error("sample outside centre");
    a_start_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (st_q == scs_pkg::SCS_RX_IDLE && st_d == scs_pkg::SCS_RX_START) |=> os_q == 4'h0)
        else $error("counter not restarted");
    a_count_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (st_q != scs_pkg::SCS_RX_IDLE && base_tick && rx_en && uart_mode)
        |=> os_q == $past(os_q) + 4'h1)
        else $error("counter did not advance");
    a_no_timer_shift: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (!uart_mode && timer_tick && !baud_tick && !pin_rise && !pin_fall) |-> !base_tick)
        else $error("timer clocked shift mode");
    a_pin_output: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (!uart_mode && !clk_dir_in) |=> shift_clock_pin_oe_o)
        else $error("shift clock not driven");
    a_shift_sample: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (!uart_mode && clk_dir_in && rx_en && pin_fall && edge_fall)
        |=> rx_bit_valid_o && rx_bit_o == $past(receive_data_pin_i))
        else $error("external edge not sampled");
    a_drive_rise: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (!uart_mode && !clk_dir_in && sample_shift) |-> sclk_d == 1'b1)
        else $error("sample not on rising edge");
    a_start_wait: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (uart_mode && st_q == scs_pkg::SCS_RX_IDLE) |=> !rx_bit_valid_o)
        else $error("sample without start bit");

    c_frame_done: cover property (@(posedge clk_sys_i) rx_frame_done_o);
    c_false_start: cover property (@(posedge clk_sys_i)
        st_q == scs_pkg::SCS_RX_START ##1 st_q == scs_pkg::SCS_RX_IDLE);
    c_shift_bit: cover property (@(posedge clk_sys_i) !uart_mode && rx_bit_valid_o);
endmodule : scs_top

/* File: scs_cfg.svh */
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH

// register byte offsets
`define SCS_OFS_MODE      4'h0
`define SCS_OFS_BAUD      4'h4
`define SCS_OFS_TIMER     4'h8
`define SCS_OFS_STATUS    4'hc

// mode register fields
`define SCS_MODE_UART_BIT 0
`define SCS_MODE_SRC_LO   1
`define SCS_MODE_DIR_BIT  3
`define SCS_MODE_EDGE_BIT 4
`define SCS_MODE_RXEN_BIT 5

// baud register fields
`define SCS_BAUD_N_LO     0
`define SCS_BAUD_K_LO     4
`define SCS_BAUD_FEN_BIT  8
`define SCS_BAUD_PRE_LO   9

// reset values
`define SCS_MODE_RST      6'h01
`define SCS_BAUD_RST      11'h001
`define SCS_TIMER_RST     8'h01

// timing counts
`define SCS_OVERSAMPLE    5'h10
`define SCS_SAMPLE_FIRST  4'h6
`define SCS_SAMPLE_LAST   4'h8
`define SCS_EXT_UART_MIN  4
`define SCS_EXT_SHIFT_MIN 16
`define SCS_FRAME_BITS    4'ha

`endif

/* File: scs_pkg.sv */
package scs_pkg;
    typedef enum logic [1:0] {
        SCS_SRC_BAUD  = 2'b00,
        SCS_SRC_HALF  = 2'b01,
        SCS_SRC_TIMER = 2'b10,
        SCS_SRC_PIN   = 2'b11
    } scs_src_t;

    typedef enum logic [1:0] {
        SCS_RX_IDLE  = 2'b00,
        SCS_RX_START = 2'b01,
        SCS_RX_DATA  = 2'b10
    } scs_rx_state_t;
endpackage : scs_pkg

/* File: scs_baud_div.sv */
`timescale 1ns/1ps
`include "scs_cfg.svh"

module scs_baud_div (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       in_en_i,
    input  wire logic [3:0] divisor_i,
    input  wire logic [3:0] fraction_i,
    input  wire logic       frac_en_i,
    output logic            tick_o
);
    // accumulator in sixteenths: with N and K not 0, period = N*16 + (16-K) input ticks / 16
    logic [8:0] acc_q, acc_d;
    logic [8:0] period;
    logic       tick_d;

    always_comb begin
        if (divisor_i == 4'h0) begin
            period = 9'h100;
        end else if (frac_en_i && fraction_i != 4'h0) begin
            period = {1'b0, divisor_i, 4'h0} + 9'h010 - {5'h00, fraction_i};
        end else begin
            period = {1'b0, divisor_i, 4'h0};
        end
        acc_d  = acc_q;
        tick_d = 1'b0;
        if (in_en_i) begin
            if (acc_q + 9'h010 >= period) begin
                acc_d  = acc_q + 9'h010 - period;
                tick_d = 1'b1;
            end else begin
                acc_d = acc_q + 9'h010;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_q  <= 9'h000;
            tick_o <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            tick_o <= tick_d;
        end
    end
endmodule : scs_baud_div

/* File: scs_timer8.sv */
`timescale 1ns/1ps
`include "scs_cfg.svh"

module scs_timer8 (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       in_en_i,
    input  wire logic [7:0] compare_i,
    output logic            trig_o
);
    // flip-flop toggles on each match; trigger output pulses on its rising edge, every second match
    logic [7:0] cnt_q, cnt_d;
    logic       ff_q, ff_d;
    logic       trig_d;

    always_comb begin
        cnt_d  = cnt_q;
        ff_d   = ff_q;
        trig_d = 1'b0;
        if (in_en_i) begin
            if (cnt_q + 8'h01 >= compare_i) begin
                cnt_d  = 8'h00;
                ff_d   = ~ff_q;
                trig_d = ~ff_q;
            end else begin
                cnt_d = cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q  <= 8'h00;
            ff_q   <= 1'b0;
            trig_o <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            ff_q   <= ff_d;
            trig_o <= trig_d;
        end
    end
endmodule : scs_timer8

/* File: scs_peer.sv */
`timescale 1ns/1ps

// ----------------------------------------
// remote transmitter and shift peer
// ----------------------------------------
module scs_peer (
    input  wire logic clk_i,
    output logic      rxd_o,
    output logic      sck_o
);
    int   hp_q  = 0;
    int   cnt_q = 0;
    logic sh_q  = 1'b0;

    initial begin
        rxd_o = 1'b1;
        sck_o = 1'b1;
    end

    // clock stands high between frames
    always @(posedge clk_i) begin
        if (hp_q > 0) begin
            cnt_q <= (cnt_q + 1 == hp_q) ? 0 : cnt_q + 1;
            if (cnt_q + 1 == hp_q) sck_o <= ~sck_o;
        end else if (!sh_q) begin
            sck_o <= 1'b1;
        end
    end

    // one idle bit, then start, data lsb first, stop; g flips two clocks mid bit
    task automatic uart(input logic [7:0] b, input int bl, input int hp, input logic g);
        logic [9:0] f;
        f    = {1'b1, b, 1'b0};
        hp_q <= hp;
        for (int i = 0; i < 11; i++) begin
            for (int c = 0; c < bl; c++) begin
                @(posedge clk_i);
                rxd_o <= (i == 0) ? 1'b1 : f[i-1] ^ (g && (c == bl/2 || c == bl/2+1));
            end
        end
        @(posedge clk_i);
        hp_q <= 0;
    endtask : uart

    task automatic low_pulse(input int n);
        @(posedge clk_i);
        rxd_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        rxd_o <= 1'b1;
    endtask : low_pulse

    // data moves away from the active edge: the other edge sees the inverse
    task automatic shift(input logic [7:0] b, input int q, input logic fe);
        sh_q <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            rxd_o <= b[i] ^ !fe;
            repeat (q) @(posedge clk_i);
            sck_o <= 1'b0;
            repeat (q) @(posedge clk_i);
            rxd_o <= b[i] ^ fe;
            repeat (q) @(posedge clk_i);
            sck_o <= 1'b1;
            repeat (q) @(posedge clk_i);
        end
        // released: line shows the inverse of the last bit
        rxd_o <= ~b[7];
        sh_q <= 1'b0;
    endtask : shift

    task automatic level(input logic v);
        @(posedge clk_i);
        rxd_o <= v;
    endtask : level
endmodule : scs_peer

/* File: tb.sv */
`timescale 1ns/1ps

module tb;
    typedef struct {
        logic [5:0]  m;
        logic [10:0] b;
        logic [7:0]  t;
        int          bl;
        int          hp;
        logic [7:0]  d;
    } scs_row_t;

    logic        clk_sys_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [3:0]  avs_address_i = 4'h0;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        shift_clock_pin_o;
    logic        shift_clock_pin_oe_o;
    logic        rx_bit_valid_o;
    logic        rx_bit_o;
    logic        rx_frame_done_o;
    logic        rxd;
    logic        peer_sck;
    wire         sck_w = shift_clock_pin_oe_o ? shift_clock_pin_o : peer_sck;
    int          err_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          nf = 0;
    int          tq[$];
    logic        bq[$];
    logic [31:0] q;
    // rows: mode, baud, timer, bit length in clocks, pin half period, byte
    scs_row_t    rows[7] = '{
        '{6'h23, 11'h001, 8'h01, 32, 0, 8'ha5},
        '{6'h21, 11'h003, 8'h01, 48, 0, 8'h5a},
        '{6'h21, 11'h000, 8'h01, 256, 0, 8'h01},
        '{6'h21, 11'h201, 8'h01, 64, 0, 8'h80},
        '{6'h21, 11'h182, 8'h01, 40, 0, 8'hc3},
        '{6'h25, 11'h001, 8'h02, 64, 0, 8'h7e},
        '{6'h27, 11'h001, 8'h01, 128, 4, 8'h69}};

    always #12.5 clk_sys_i = ~clk_sys_i;

    scs_top scs_top_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .shift_clock_pin_i(sck_w), .shift_clock_pin_o(shift_clock_pin_o),
        .shift_clock_pin_oe_o(shift_clock_pin_oe_o), .receive_data_pin_i(rxd),
        .rx_bit_valid_o(rx_bit_valid_o), .rx_bit_o(rx_bit_o), .rx_frame_done_o(rx_frame_done_o));

    scs_peer scs_peer_i (.clk_i(clk_sys_i), .rxd_o(rxd), .sck_o(peer_sck));

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc > 40000) begin
            err_count++;
            summarize();
        end
    end

    // outputs settle by the falling edge
    always @(negedge clk_sys_i) begin
        if (rx_bit_valid_o === 1'b1) begin
            bq.push_back(rx_bit_o);
            tq.push_back(cyc);
        end
        if (rx_frame_done_o === 1'b1) nf++;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %0t %s got %h", $time, m, got);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        logic done;
        int   t;
        @(posedge clk_sys_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= w;
        avs_read_i      <= ~w;
        done = 1'b0;
        t    = 0;
        // sampled at the rising edge; only the global timeout ends a hang
        while (!done) begin
            @(posedge clk_sys_i);
            done = (avs_waitrequest_o === 1'b0);
            r    = avs_readdata_o;
            t++;
        end
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        chk(t, 2, "bus answer");
    endtask : bus

    task automatic cfg(input logic [5:0] m, input logic [10:0] b, input logic [7:0] t);
        bus(1'b1, 4'h4, {21'h0, b}, q);
        bus(1'b1, 4'h8, {24'h0, t}, q);
        bus(1'b1, 4'h0, {26'h0, m}, q);
        bus(1'b0, 4'h0, 32'h0, q);
        chk(q, {26'h0, m}, "mode readback");
        bq.delete();
        tq.delete();
        nf = 0;
    endtask : cfg

    task automatic chk_bits(input logic [9:0] f, input int n, input int bl);
        chk(bq.size(), n, "bit count");
        for (int k = 0; k < n && k < bq.size(); k++) begin
            chk({31'h0, bq[k]}, {31'h0, f[k]}, "bit value");
            if (k > 0 && bl > 0) chk(tq[k] - tq[k-1], bl, "bit spacing");
        end
    endtask : chk_bits

    task automatic wait_frame(input int bl);
        int t;
        t = 0;
        while (nf == 0 && t < 4 * bl) begin
            @(posedge clk_sys_i);
            t++;
        end
    endtask : wait_frame

    initial begin
        repeat (6) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        bus(1'b0, 4'h0, 32'h0, q);
        chk(q, 32'h1, "mode reset");
        bus(1'b0, 4'h4, 32'h0, q);
        chk(q, 32'h1, "baud reset");
        bus(1'b0, 4'h8, 32'h0, q);
        chk(q, 32'h1, "timer reset");
        bus(1'b1, 4'hc, 32'hffffffff, q);
        bus(1'b0, 4'hc, 32'h0, q);
        chk(q, 32'h4, "status read only");
        bus(1'b1, 4'h2, 32'hff, q);
        bus(1'b0, 4'h2, 32'h0, q);
        chk(q, 32'h0, "unmapped read");
        foreach (rows[i]) begin
            cfg(rows[i].m, rows[i].b, rows[i].t);
            scs_peer_i.uart(rows[i].d, rows[i].bl, rows[i].hp, 1'b0);
            wait_frame(rows[i].bl);
            chk_bits({1'b1, rows[i].d, 1'b0}, 10, rows[i].bl);
            chk(nf, 1, "frame done");
        end
        // one tick of noise in every bit must be voted away
        cfg(6'h23, 11'h001, 8'h01);
        scs_peer_i.uart(8'h3c, 32, 0, 1'b1);
        wait_frame(32);
        chk_bits({1'b1, 8'h3c, 1'b0}, 10, 32);
        cfg(6'h23, 11'h001, 8'h01);
        scs_peer_i.low_pulse(2);
        repeat (12 * 32) @(posedge clk_sys_i);
        chk(nf, 0, "false start");
        chk(bq.size(), 0, "false start bits");
        cfg(6'h03, 11'h001, 8'h01);
        scs_peer_i.uart(8'h55, 32, 0, 1'b0);
        chk(nf + bq.size(), 0, "receiver disabled");
        for (int e = 0; e < 2; e++) begin
            cfg(6'h28 | 6'(e << 4), 11'h001, 8'h01);
            scs_peer_i.shift(8'h96, 5, e[0]);
            repeat (4) @(posedge clk_sys_i);
            chk_bits({2'b0, 8'h96}, 8, 0);
            chk({31'h0, shift_clock_pin_oe_o}, 32'h0, "pin input");
        end
        // timer source field must be ignored in shift mode
        scs_peer_i.level(1'b1);
        cfg(6'h24, 11'h004, 8'h01);
        wait (bq.size() >= 6 || cyc > 39000);
        chk_bits(10'h3ff, 6, 8);
        chk({31'h0, shift_clock_pin_o}, 32'h1, "pin high at sample");
        chk({31'h0, shift_clock_pin_oe_o}, 32'h1, "pin output");
        @(posedge clk_sys_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        chk({30'h0, shift_clock_pin_o, shift_clock_pin_oe_o}, 32'h2, "pin in reset");
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        bus(1'b0, 4'h0, 32'h0, q);
        chk(q, 32'h1, "mode after reset");
        summarize();
    end
endmodule : tb
